// ==== usb_host_glue_status_reset.sv ====
// Glue register bank: source status, interrupt forcing, resets and config
//
// Functional notes
// - Status reads show live unlatched source levels
// - Remote wake pulses on suspend to resume
// - Remote wake only when core wakeup enabled
// - Buffer access high while core uses memory
// - Status bit 9 is core irq, active low
// - Abort pulses low for at least 10 us
// - Overcurrent follows pin, feeds core when clocked
// - Test mode plus enable: force bits drive irq
// - Force bits 7..11 map to five sources
// - External reset sets both force-reset bits
// - Bit 0 holds master interface in reset
// - Bit 1 holds host core in reset
// - Bit 2 resets clock generator, test only
// - Bit 3 shortens frame tick for test
// - Bit 5 in sleep disables receiver, power
// - Bit 6 selects overcurrent sense polarity
// - Bit 7 selects port power output polarity
// - Power pin takes inverted standby bit, then bit 7 polarity, when asleep
// - Six sources merge into one interrupt
`timescale 1ns/1ns
`include "usb_glue_map.svh"
module usb_host_glue_status_reset
  import usb_glue_pkg::*;
#(
  parameter int unsigned ABORT_CYC = `ABORT_MIN_CYC
) (
  input  wire logic        clk_sys,                // System clock
  input  wire logic        reset_n,                // Sync reset, active low
  // Register access bus
  input  wire logic        reg_write_strobe,       // Write strobe
  input  wire logic        reg_read_enable,        // Read enable
  input  wire logic [8:2]  reg_addr,               // Word address
  input  wire logic [31:0] reg_wdata,              // Write data
  input  wire logic [3:0]  reg_byte_en,            // Byte enables
  output logic      [31:0] reg_rdata,              // Read data
  output logic             reg_wait,               // Read not yet ready
  // Host core side
  input  wire logic        core_suspended,         // Core in suspend
  input  wire logic        core_rwe,               // Remote wakeup enable
  input  wire logic        core_buffer_busy,       // Core uses shared memory
  input  wire logic        core_irq_n,             // Core irq, active low
  input  wire logic        core_abort,             // Transfer cannot go on
  input  wire logic        core_port_power,        // Root port power status
  input  wire logic        port_resume_in,         // Port resume condition
  output logic             core_overcurrent,       // Overcurrent to core
  output logic             core_reset,             // Core reset
  output logic             master_if_reset,        // DMA master reset
  output logic             clock_gen_reset,        // Clock generator reset
  output logic             frame_tick_scaledown,   // Short frame tick
  // System state
  input  wire logic        test_mode,              // Chip test mode
  input  wire logic        sleep_active,           // Sleep mode
  input  wire logic        usb_clk_running,        // USB clock runs
  // Pins
  input  wire logic        overcurrent_sense_pin,  // Overcurrent sense
  output logic             port_power_control_pin, // Port power switch
  output logic             receiver_disable,       // Single-ended rx off
  // Interrupt controller
  output logic             combined_irq_out        // Combined interrupt
);

  localparam logic [6:0] IDX_STATUS = 7'(`OFS_SOURCE_STATUS >> 2);
  localparam logic [6:0] IDX_FORCE  = 7'(`OFS_FORCE_TEST >> 2);
  localparam logic [6:0] IDX_CONFIG = 7'(`OFS_RESET_CONFIG >> 2);
  localparam int unsigned SW = `SRC_MSB - `SRC_LSB + 1;

  irq_src_if src_bus ();

  logic [SW-1:0]       force_ff;
  logic [`CFG_MSB:0]   config_ff;
  logic [31:0]         rdata_ff;
  logic                rd_done_ff;
  logic                irq_ff;
  logic                pwr_pin_ff;
  logic                rx_dis_ff;

  wire  reg_sel_t      sel;
  wire  logic          word_write;
  wire  logic          wr_force;
  wire  logic          wr_config;
  wire  logic          rd_take;
  wire  logic [SW-1:0] live_src;
  wire  logic [SW-1:0] force_src;
  wire  logic          live_any;
  wire  logic          force_any;
  wire  logic          forcing;
  wire  logic          asleep;
  wire  logic          pwr_level;
  wire  logic [31:0]   status_word;
  wire  logic [31:0]   force_word;
  wire  logic [31:0]   config_word;
  wire  logic [31:0]   read_mux;

  // Config field views
  wire logic force_if_rst   = config_ff[`BIT_FORCE_IF_RST];
  wire logic force_core_rst = config_ff[`BIT_FORCE_CORE_RST];
  wire logic clkgen_rst     = config_ff[`BIT_CLKGEN_RST];
  wire logic scaledown      = config_ff[`BIT_SCALEDOWN];
  wire logic irq_test_en    = config_ff[`BIT_IRQ_TEST_EN];
  wire logic standby_en     = config_ff[`BIT_STANDBY_EN];
  wire logic sense_pol_low  = config_ff[`BIT_SENSE_POL_LOW];
  wire logic pwr_pol_low    = config_ff[`BIT_PWR_POL_LOW];

  // Place a source-wide field at its register bits
  function automatic logic [31:0] place_src(input logic [SW-1:0] f);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`SRC_MSB:`SRC_LSB] = f;
    return w;
  endfunction

  irq_src_shaper #(
    .ABORT_CYC (ABORT_CYC)
  ) u_shaper (
    .clk_sys          (clk_sys),
    .reset_n          (reset_n),
    .core_suspended   (core_suspended),
    .core_rwe         (core_rwe),
    .core_buffer_busy (core_buffer_busy),
    .core_irq_n       (core_irq_n),
    .core_abort       (core_abort),
    .sense_in         (overcurrent_sense_pin),
    .sense_pol_low    (sense_pol_low),
    .port_resume_in   (port_resume_in),
    .src              (src_bus.shaper)
  );

  // Address decode
  assign sel = (reg_addr == IDX_STATUS) ? SEL_STATUS :
               (reg_addr == IDX_FORCE)  ? SEL_FORCE  :
               (reg_addr == IDX_CONFIG) ? SEL_CONFIG : SEL_NONE;

  // Partial-word writes are dropped
  assign word_write = reg_write_strobe & (reg_byte_en == 4'hf);
  assign wr_force   = word_write & (sel == SEL_FORCE);
  assign wr_config  = word_write & (sel == SEL_CONFIG);

  // Live source levels in status bit order
  assign live_src = {src_bus.overcurrent_flag,
                     src_bus.transfer_abort_n,
                     src_bus.normal_core_irq_n,
                     src_bus.buffer_access_flag,
                     src_bus.remote_wake_flag};

  assign status_word = place_src(live_src);
  assign force_word  = place_src(force_ff);
  assign config_word = {24'h00_0000, config_ff};

  assign read_mux = (sel == SEL_STATUS) ? status_word :
                    (sel == SEL_FORCE)  ? force_word  :
                    (sel == SEL_CONFIG) ? config_word : 32'h0000_0000;

  // Reads answer one cycle after the enable
  assign rd_take  = reg_read_enable & ~rd_done_ff;
  assign reg_wait = rd_take;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rd_done_ff <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      rd_done_ff <= rd_take;
      if (rd_take) begin
        rdata_ff <= read_mux;
      end
    end
  end

  assign reg_rdata = rdata_ff;

  // Force-test register, reserved bits never stored
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      force_ff <= `RST_FORCE_TEST;
    end else if (wr_force) begin
      force_ff <= reg_wdata[`SRC_MSB:`SRC_LSB];
    end
  end

  // Reset/config register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      config_ff <= `RST_RESET_CONFIG;
    end else if (wr_config) begin
      config_ff <= reg_wdata[`CFG_MSB:0];
    end
  end

  // Unit resets
  assign master_if_reset      = force_if_rst | ~reset_n;
  assign core_reset           = force_core_rst | ~reset_n;
  assign clock_gen_reset      = clkgen_rst;
  assign frame_tick_scaledown = scaledown;

  // Overcurrent to core only with its clock running
  assign core_overcurrent = src_bus.overcurrent_flag & usb_clk_running;

  // Interrupt merge and test forcing
  assign forcing   = test_mode & irq_test_en;
  assign force_src = force_ff;
  assign live_any  = src_bus.remote_wake_flag |
                     src_bus.buffer_access_flag |
                     ~src_bus.normal_core_irq_n |
                     ~src_bus.transfer_abort_n |
                     src_bus.overcurrent_flag |
                     src_bus.port_resume;
  assign force_any = |force_src;

  // Sleep handling of the port power and receiver
  assign asleep    = sleep_active | ~usb_clk_running;
  assign pwr_level = asleep ? ~standby_en : core_port_power;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_ff     <= 1'b0;
      pwr_pin_ff <= 1'b0;
      rx_dis_ff  <= 1'b0;
    end else begin
      irq_ff     <= forcing ? force_any : live_any;
      pwr_pin_ff <= pwr_level ^ pwr_pol_low;
      rx_dis_ff  <= sleep_active & standby_en;
    end
  end

  assign combined_irq_out       = irq_ff;
  assign port_power_control_pin = pwr_pin_ff;
  assign receiver_disable       = rx_dis_ff;

endmodule

// ==== usb_glue_map.svh ====
// Offsets, field positions, reset values and timing counts of the glue block
`ifndef USB_GLUE_MAP_SVH
`define USB_GLUE_MAP_SVH

// Byte offsets of the glue registers
`define OFS_SOURCE_STATUS   12'h518
`define OFS_FORCE_TEST      12'h520
`define OFS_RESET_CONFIG    12'h51c

// Status and force-test field positions
`define BIT_REMOTE_WAKE     7
`define BIT_BUFFER_ACCESS   8
`define BIT_NORMAL_IRQ      9
`define BIT_TRANSFER_ABORT  10
`define BIT_OVERCURRENT     11
`define BIT_PORT_RESUME     11
`define SRC_LSB             7
`define SRC_MSB             11

// Reset/config field positions
`define BIT_FORCE_IF_RST    0
`define BIT_FORCE_CORE_RST  1
`define BIT_CLKGEN_RST      2
`define BIT_SCALEDOWN       3
`define BIT_IRQ_TEST_EN     4
`define BIT_STANDBY_EN      5
`define BIT_SENSE_POL_LOW   6
`define BIT_PWR_POL_LOW     7
`define CFG_MSB             7

// Reset values
`define RST_FORCE_TEST      5'h00
`define RST_RESET_CONFIG    8'h03

// Timing
`define CLK_MHZ             100
`define ABORT_MIN_NS        10000
`define ABORT_MIN_CYC       ((`ABORT_MIN_NS * `CLK_MHZ + 999) / 1000)

`endif

// ==== usb_glue_pkg.sv ====
// Types shared by the glue block modules
package usb_glue_pkg;

  typedef enum logic [3:0] {
    SEL_NONE   = 4'b0001,
    SEL_STATUS = 4'b0010,
    SEL_FORCE  = 4'b0100,
    SEL_CONFIG = 4'b1000
  } reg_sel_t;

  typedef enum logic [1:0] {
    ABORT_IDLE = 2'b01,
    ABORT_HOLD = 2'b10
  } abort_state_t;

endpackage

// ==== irq_src_if.sv ====
// Live interrupt source levels from the shaper to the register bank
`timescale 1ns/1ns
interface irq_src_if;
  logic remote_wake_flag;
  logic buffer_access_flag;
  logic normal_core_irq_n;
  logic transfer_abort_n;
  logic overcurrent_flag;
  logic port_resume;

  modport shaper (
    output remote_wake_flag,
    output buffer_access_flag,
    output normal_core_irq_n,
    output transfer_abort_n,
    output overcurrent_flag,
    output port_resume
  );

  modport bank (
    input remote_wake_flag,
    input buffer_access_flag,
    input normal_core_irq_n,
    input transfer_abort_n,
    input overcurrent_flag,
    input port_resume
  );
endinterface

// ==== irq_src_shaper.sv ====
// Shapes raw host core conditions into live interrupt source levels
`timescale 1ns/1ns
`include "usb_glue_map.svh"
module irq_src_shaper
  import usb_glue_pkg::*;
#(
  parameter int unsigned ABORT_CYC = `ABORT_MIN_CYC
) (
  input  wire logic  clk_sys,              // System clock
  input  wire logic  reset_n,              // Synchronous reset, active low
  input  wire logic  core_suspended,       // Core in suspend state
  input  wire logic  core_rwe,             // Core remote wakeup enable
  input  wire logic  core_buffer_busy,     // Core touching shared memory
  input  wire logic  core_irq_n,           // Core normal irq, active low
  input  wire logic  core_abort,           // Core cannot continue transfer
  input  wire logic  sense_in,             // Overcurrent pin level
  input  wire logic  sense_pol_low,        // Pin is active low
  input  wire logic  port_resume_in,       // Port resume condition
  irq_src_if.shaper  src                   // Shaped source levels
);

  localparam int unsigned CW = $clog2(ABORT_CYC + 1);

  logic          suspended_ff;
  abort_state_t  abort_st_ff;
  abort_state_t  nxt_abort_st;
  logic [CW-1:0] abort_cnt_ff;
  logic [CW-1:0] nxt_abort_cnt;
  wire  logic    resume_edge;
  wire  logic    hold_done;

  // Suspend to resume transition
  assign resume_edge = suspended_ff & ~core_suspended;
  assign hold_done   = (abort_cnt_ff == CW'(ABORT_CYC - 1));

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      suspended_ff <= 1'b0;
      abort_st_ff  <= ABORT_IDLE;
      abort_cnt_ff <= '0;
    end else begin
      suspended_ff <= core_suspended;
      abort_st_ff  <= nxt_abort_st;
      abort_cnt_ff <= nxt_abort_cnt;
    end
  end

  // Abort low pulse stretched to its least width
  always_comb begin
    nxt_abort_st  = abort_st_ff;
    nxt_abort_cnt = abort_cnt_ff;
    unique case (abort_st_ff)
      ABORT_IDLE: begin
        nxt_abort_cnt = '0;
        if (core_abort) begin
          nxt_abort_st = ABORT_HOLD;
        end
      end
      ABORT_HOLD: begin
        if (!hold_done) begin
          nxt_abort_cnt = abort_cnt_ff + CW'(1);
        end else if (!core_abort) begin
          nxt_abort_st = ABORT_IDLE;
        end
      end
      default: begin
        nxt_abort_st  = ABORT_IDLE;
        nxt_abort_cnt = '0;
      end
    endcase
  end

  assign src.remote_wake_flag   = resume_edge & core_rwe;
  assign src.buffer_access_flag = core_buffer_busy;
  assign src.normal_core_irq_n  = core_irq_n;
  assign src.transfer_abort_n   = ~(core_abort | (abort_st_ff == ABORT_HOLD));
  assign src.overcurrent_flag   = sense_in ^ sense_pol_low;
  assign src.port_resume        = port_resume_in;

endmodule

// ==== usb_glue_checker.sv ====
// Concurrent checks on the glue register bank ports
`timescale 1ns/1ns
module usb_glue_checker #(
  parameter int unsigned ABORT_CYC = 8
) (
  input wire logic clk_sys,          // Clock
  input wire logic reset_n,          // Reset
  input wire logic reg_write_strobe, // Write
  input wire logic reg_read_enable,  // Read
  input wire logic reg_wait,         // Wait
  input wire logic core_suspended,   // Suspend
  input wire logic core_rwe,         // Wake enable
  input wire logic core_buffer_busy, // Buffer use
  input wire logic core_abort,       // Abort
  input wire logic test_mode,        // Test mode
  input wire logic sleep_active,     // Sleep
  input wire logic usb_clk_running,  // Clock runs
  input wire logic core_overcurrent, // To core
  input wire logic core_reset,       // Core reset
  input wire logic master_if_reset,  // Master reset
  input wire logic receiver_disable, // Rx off
  input wire logic combined_irq_out  // Irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  rst_hold_a: assert property (disable iff (1'b0)
    !reset_n |-> core_reset && master_if_reset)
    else $error("resets not held during reset");
  core_rel_a: assert property (
    $fell(core_reset) |-> $past(reg_write_strobe))
    else $error("core reset dropped without a write");
  mif_rel_a: assert property (
    $fell(master_if_reset) |-> $past(reg_write_strobe))
    else $error("master reset dropped without a write");
  ovc_clk_a: assert property (
    !usb_clk_running |-> !core_overcurrent)
    else $error("overcurrent sent to a stopped core");
  rx_sleep_a: assert property (
    receiver_disable |-> $past(sleep_active))
    else $error("receiver off outside sleep");
  buf_irq_a: assert property (
    !test_mode && core_buffer_busy |-> ##[1:2] combined_irq_out)
    else $error("buffer activity gave no interrupt");
  wake_irq_a: assert property (
    $fell(core_suspended) && core_rwe && !test_mode
      |-> ##[1:3] combined_irq_out)
    else $error("resume gave no interrupt");
  rd_wait_a: assert property (
    $rose(reg_read_enable) |-> reg_wait ##1 !reg_wait)
    else $error("read wait not one cycle");
  abort_irq_a: assert property (
    $rose(core_abort) && !test_mode && ABORT_CYC >= 8
      |-> ##2 combined_irq_out [*6])
    else $error("abort interrupt too short");

  cover property ($fell(core_suspended) && core_rwe);
  cover property ($rose(core_abort));
  cover property (test_mode && combined_irq_out);
endmodule

bind usb_host_glue_status_reset usb_glue_checker #(
  .ABORT_CYC(ABORT_CYC)
) u_chk (
  .clk_sys(clk_sys), .reset_n(reset_n),
  .reg_write_strobe(reg_write_strobe), .reg_read_enable(reg_read_enable),
  .reg_wait(reg_wait), .core_suspended(core_suspended),
  .core_rwe(core_rwe), .core_buffer_busy(core_buffer_busy),
  .core_abort(core_abort), .test_mode(test_mode),
  .sleep_active(sleep_active), .usb_clk_running(usb_clk_running),
  .core_overcurrent(core_overcurrent), .core_reset(core_reset),
  .master_if_reset(master_if_reset), .receiver_disable(receiver_disable),
  .combined_irq_out(combined_irq_out)
);

// ==== irq_ctrl_model.sv ====
// Interrupt controller stand-in that latches the combined line
`timescale 1ns/1ns
module irq_ctrl_model (
  input  wire logic clk_sys, // Clock
  input  wire logic reset_n, // Reset
  input  wire logic irq_in,  // Combined irq
  input  wire logic clear,   // Drop request
  output logic      pending  // Latched request
);
  logic pending_ff;
  always_ff @(posedge clk_sys) begin
    if (!reset_n || clear) begin
      pending_ff <= 1'b0;
    end else if (irq_in) begin
      pending_ff <= 1'b1;
    end
  end
  assign pending = pending_ff;
endmodule

// ==== usb_host_glue_status_reset_tb_top.sv ====
// Self-checking bench for the glue register bank
`timescale 1ns/1ns
module usb_host_glue_status_reset_tb_top;
  typedef struct packed {
    logic [8:2]  a;
    logic [3:0]  b;
    logic [31:0] w;
    logic [31:0] r;
  } row_t;
  logic        clk_sys = 1'b0, reset_n = 1'b0, stb = 1'b0, ren = 1'b0;
  logic [8:2]  addr = '0;
  logic [31:0] wdata = '0, rdata, v;
  logic [3:0]  be = 4'hf;
  logic        wt, susp, rwe, busy, irq_n, abrt, ppwr, resm;
  logic        tmode, slp, crun, pin, clr, pend;
  logic        ovc, c_rst, m_rst, g_rst, scl, ppin, rx_dis, irq;
  int          fail_count = 0, comparisons = 0;
  row_t        rows [7] = '{
    '{7'h47, 4'hf, 32'h00000000, 32'h00000000},
    '{7'h48, 4'hf, 32'hffffffff, 32'h00000f80},
    '{7'h48, 4'h1, 32'h00000000, 32'h00000f80},
    '{7'h46, 4'hf, 32'hffffffff, 32'h00000600},
    '{7'h49, 4'hf, 32'hffffffff, 32'h00000000},
    '{7'h47, 4'hf, 32'hffffff7c, 32'h0000007c},
    '{7'h48, 4'hf, 32'h00000000, 32'h00000000}};

  always #5 clk_sys = ~clk_sys;

  usb_host_glue_status_reset #(.ABORT_CYC(8)) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_write_strobe(stb),
    .reg_read_enable(ren), .reg_addr(addr), .reg_wdata(wdata),
    .reg_byte_en(be), .reg_rdata(rdata), .reg_wait(wt),
    .core_suspended(susp), .core_rwe(rwe), .core_buffer_busy(busy),
    .core_irq_n(irq_n), .core_abort(abrt), .core_port_power(ppwr),
    .port_resume_in(resm), .core_overcurrent(ovc), .core_reset(c_rst),
    .master_if_reset(m_rst), .clock_gen_reset(g_rst),
    .frame_tick_scaledown(scl), .test_mode(tmode), .sleep_active(slp),
    .usb_clk_running(crun), .overcurrent_sense_pin(pin),
    .port_power_control_pin(ppin), .receiver_disable(rx_dis),
    .combined_irq_out(irq));

  irq_ctrl_model u_irqc (.clk_sys(clk_sys), .reset_n(reset_n),
    .irq_in(irq), .clear(clr), .pending(pend));

  task automatic chk(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [8:2] a, input logic [31:0] d,
                    input logic [3:0] b = 4'hf);
    @(posedge clk_sys);
    stb <= 1'b1;
    addr <= a;
    wdata <= d;
    be <= b;
    @(posedge clk_sys);
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [8:2] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    ren <= 1'b1;
    addr <= a;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (wt !== 1'b0 && n < 8);
    if (n == 8) fail_count++;
    d = rdata;
    @(posedge clk_sys);
    ren <= 1'b0;
  endtask

  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk_sys);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    {susp, rwe, busy, abrt, ppwr, resm, tmode, slp, pin, clr} = '0;
    irq_n = 1'b1;
    crun = 1'b1;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w, rows[i].b);
      rd(rows[i].a, v);
      chk("table", v, rows[i].r);
    end
    #1;
    chk("core_reset", 32'(c_rst), 32'h0);
    chk("master_reset", 32'(m_rst), 32'h0);
    wr(7'h47, 32'h0);
    busy <= 1'b1;
    irq_n <= 1'b0;
    pin <= 1'b1;
    rd(7'h46, v);
    chk("status", v, 32'h00000d00);
    chk("overcurrent", 32'(ovc), 32'h1);
    wr(7'h47, 32'h40);
    rd(7'h46, v);
    chk("status_pol", v, 32'h00000500);
    tmode <= 1'b1;
    wr(7'h47, 32'h50);
    wr(7'h48, 32'h0);
    settle();
    chk("irq_masked", 32'(irq), 32'h0);
    for (int k = 7; k <= 11; k++) begin
      wr(7'h48, 32'h1 << k);
      settle();
      chk("irq_forced", 32'(irq), 32'h1);
    end
    wr(7'h48, 32'h0);
    tmode <= 1'b0;
    settle();
    chk("irq_live", 32'(irq), 32'h1);
    @(posedge clk_sys);
    busy <= 1'b0;
    irq_n <= 1'b1;
    susp <= 1'b1;
    clr <= 1'b1;
    repeat (4) @(posedge clk_sys);
    susp <= 1'b0;
    clr <= 1'b0;
    settle();
    chk("wake_off", 32'(pend), 32'h0);
    @(posedge clk_sys);
    susp <= 1'b1;
    rwe <= 1'b1;
    repeat (2) @(posedge clk_sys);
    susp <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("wake_on", 32'(pend), 32'h1);
    @(posedge clk_sys);
    abrt <= 1'b1;
    @(posedge clk_sys);
    abrt <= 1'b0;
    rd(7'h46, v);
    chk("abort_low", v, 32'h00000200);
    repeat (10) @(posedge clk_sys);
    rd(7'h46, v);
    chk("abort_end", v, 32'h00000600);
    ppwr <= 1'b1;
    wr(7'h47, 32'h0c);
    settle();
    chk("power_pin", 32'(ppin), 32'h1);
    chk("clkgen_reset", 32'(g_rst), 32'h1);
    chk("scaledown", 32'(scl), 32'h1);
    wr(7'h47, 32'h80);
    settle();
    chk("power_pol", 32'(ppin), 32'h0);
    wr(7'h47, 32'h20);
    slp <= 1'b1;
    settle();
    chk("power_sleep", 32'(ppin), 32'h0);
    chk("rx_off", 32'(rx_dis), 32'h1);
    wr(7'h47, 32'h0);
    settle();
    chk("power_sleep", 32'(ppin), 32'h1);
    chk("rx_on", 32'(rx_dis), 32'h0);
    wr(7'h47, 32'h24);
    slp <= 1'b0;
    crun <= 1'b0;
    settle();
    chk("power_noclk", 32'(ppin), 32'h0);
    chk("ovc_noclk", 32'(ovc), 32'h0);
    @(posedge clk_sys);
    pin <= 1'b0;
    clr <= 1'b1;
    settle();
    chk("irq_idle", 32'(irq), 32'h0);
    @(posedge clk_sys);
    clr <= 1'b0;
    resm <= 1'b1;
    settle();
    chk("irq_resume", 32'(irq), 32'h1);
    chk("resume_seen", 32'(pend), 32'h1);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1;
    chk("core_reset", 32'(c_rst), 32'h1);
    chk("master_reset", 32'(m_rst), 32'h1);
    chk("clkgen_reset", 32'(g_rst), 32'h0);
    rd(7'h47, v);
    chk("config_reset", v, 32'h00000003);
    tally_and_finish();
  end
endmodule
